/* copro_model.sv */
// Behavioural coprocessor answering the port handshakes
module copro_model
  import copro_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic internalRun,
  input wire logic execute_entry_flag,
  input wire logic wantWait,
  input wire logic wantBounce,
  input wire logic rejD,
  input wire logic [7:0] waitLen,
  input wire logic [DATA_W-1:0] regValue,
  input wire logic pipelineHold,
  input wire logic commitStrobe,
  input wire logic commit_flag,
  output logic decode_reject_input,
  output logic decode_wait_request,
  output logic execute_wait_continue,
  output logic execute_reject_input,
  output logic [DATA_W-1:0] copro_data_bus_in,
  output logic [7:0] doneCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic heldExec;
  logic driveData;
  assign decode_reject_input = rejD;
  assign decode_wait_request = wantWait;
  // Drive lasts through an interlock; elsewhere the inverse so a stale capture cannot pass
  assign driveData = execute_entry_flag || heldExec;
  assign copro_data_bus_in = driveData ? regValue : ~regValue;
  // Steps only while internalRun is high, a registered copy of run, so a stall freezes it one cycle after the port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      execute_wait_continue <= 1'b0;
      execute_reject_input <= 1'b0;
      heldExec <= 1'b0;
      doneCount <= 8'h00;
    end else if (internalRun) begin
      execute_reject_input <= 1'b0;
      heldExec <= driveData && pipelineHold;
      // Only a completed instruction may change coprocessor state
      if (commitStrobe && commit_flag) begin
        doneCount <= doneCount + 8'h01;
      end
      if (execute_entry_flag && wantWait && !rejD) begin
        execute_wait_continue <= 1'b1;
        cnt <= waitLen;
      end else if (execute_wait_continue) begin
        if (cnt <= 8'h01) begin
          execute_wait_continue <= 1'b0;
          execute_reject_input <= wantBounce;
        end
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

/* copro_port_pkg.sv */
// Constants and types shared by the coprocessor handshake port
package copro_port_pkg;
  localparam int DATA_W = 32;
  localparam int INSTR_W = 26;
  localparam int CLASS_HI = 27;
  localparam int CLASS_LO = 25;
  localparam logic [2:0] COPRO_CLASS = 3'h7;
  localparam logic [1:0] NON_COPRO_TAG = 2'h3;
  localparam logic [INSTR_W-1:0] INSTR_IDLE = 26'h0000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic PRIV_HIGH = 1'h1;
  localparam logic PRIV_LOW = 1'h0;
  typedef enum logic [3:0] {
    EX_IDLE = 4'h1,
    EX_RUN = 4'h2,
    EX_WAIT = 4'h4,
    EX_DONE = 4'h8
  } exec_state_t;
endpackage

/* coprocessor_handshake_port.sv */
// Processor-side coprocessor handshake port
module coprocessor_handshake_port
  import copro_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic coreDecodeValid,
  input wire logic [DATA_W-1:0] coreDecodeInstr,
  input wire logic corePrivileged,
  input wire logic coreExecuteValid,
  input wire logic coreCondPass,
  input wire logic coreInterlock,
  input wire logic [DATA_W-1:0] coreMoveToData,
  input wire logic memStall,
  input wire logic decode_reject_input,
  input wire logic execute_reject_input,
  input wire logic decode_wait_request,
  input wire logic execute_wait_continue,
  input wire logic [DATA_W-1:0] copro_data_bus_in,
  output logic [DATA_W-1:0] copro_data_bus_out,
  output logic copro_data_bus_oe,
  output logic [INSTR_W-1:0] copro_instr_bits,
  output logic decode_entry_flag,
  output logic execute_entry_flag,
  output logic commit_flag,
  output logic commitStrobe,
  output logic bounceStrobe,
  output logic pipelineHold,
  output logic privilege_level_output,
  output logic [DATA_W-1:0] virtual_addr_bus,
  output logic [DATA_W-1:0] moveFromData,
  output logic internalRun
);

  exec_state_t state;
  exec_state_t next_state;
  logic stallSync1;
  logic stallSync2;
  logic run;
  logic entryWait;
  logic entryBounce;
  logic isCopro;

  // Stall gate is a memory-system pin, so it is synchronised first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stallSync1 <= 1'b0;
      stallSync2 <= 1'b0;
    end else begin
      stallSync1 <= memStall;
      stallSync2 <= stallSync1;
    end
  end

  // A held internal clock is modelled as the pipeline not advancing
  assign run = !stallSync2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      internalRun <= 1'b0;
    end else begin
      internalRun <= run;
    end
  end

  assign isCopro = (coreDecodeInstr[CLASS_HI:CLASS_LO] == COPRO_CLASS);

  // Decode-side broadcast; idle bits are zero, a non-coprocessor instruction sends NON_COPRO_TAG over zero bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      copro_instr_bits <= INSTR_IDLE;
      decode_entry_flag <= 1'b0;
      privilege_level_output <= PRIV_LOW;
    end else if (run) begin
      decode_entry_flag <= coreDecodeValid;
      privilege_level_output <= coreDecodeValid ? corePrivileged : PRIV_LOW;
      if (!coreDecodeValid) begin
        copro_instr_bits <= INSTR_IDLE;
      end else if (isCopro) begin
        copro_instr_bits <= coreDecodeInstr[INSTR_W-1:0];
      end else begin
        copro_instr_bits <= {NON_COPRO_TAG, 24'h000000};
      end
    end
  end

  // Execute entry and the hold warning
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      execute_entry_flag <= 1'b0;
      pipelineHold <= 1'b0;
    end else if (run) begin
      execute_entry_flag <= coreExecuteValid;
      pipelineHold <= coreInterlock;
    end
  end

  // Answers seen while the instruction sat in decode are latched at entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entryWait <= 1'b0;
      entryBounce <= 1'b0;
    end else if (run && coreExecuteValid) begin
      entryWait <= decode_wait_request;
      entryBounce <= decode_reject_input;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      EX_IDLE: begin
        if (coreExecuteValid) begin
          next_state = EX_RUN;
        end
      end
      EX_RUN: begin
        if (pipelineHold) begin
          next_state = EX_RUN;
        end else if (entryWait && !entryBounce) begin
          next_state = EX_WAIT;
        end else begin
          next_state = EX_DONE;
        end
      end
      EX_WAIT: begin
        if (execute_reject_input || !execute_wait_continue) begin
          next_state = EX_DONE;
        end
      end
      EX_DONE: begin
        next_state = coreExecuteValid ? EX_RUN : EX_IDLE;
      end
      default: begin
        next_state = EX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= EX_IDLE;
    end else if (run) begin
      state <= next_state;
    end
  end

  // Commit decision; a bounce always cancels so the coprocessor keeps its state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      commit_flag <= 1'b0;
      commitStrobe <= 1'b0;
      bounceStrobe <= 1'b0;
    end else if (run) begin
      commitStrobe <= 1'b0;
      bounceStrobe <= 1'b0;
      if (state == EX_RUN && !pipelineHold && !(entryWait && !entryBounce)) begin
        commit_flag <= coreCondPass && !entryBounce;
        commitStrobe <= 1'b1;
        bounceStrobe <= entryBounce;
      end else if (state == EX_WAIT && (execute_reject_input || !execute_wait_continue)) begin
        commit_flag <= coreCondPass && !execute_reject_input;
        commitStrobe <= 1'b1;
        bounceStrobe <= execute_reject_input;
      end
    end else begin
      commitStrobe <= 1'b0;
      bounceStrobe <= 1'b0;
    end
  end

  // Move-to data rides the address bus; the data bus stays an input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      virtual_addr_bus <= DATA_RESET;
      copro_data_bus_out <= DATA_RESET;
      copro_data_bus_oe <= 1'b0;
      moveFromData <= DATA_RESET;
    end else if (run) begin
      virtual_addr_bus <= coreMoveToData;
      copro_data_bus_out <= DATA_RESET;
      copro_data_bus_oe <= 1'b0;
      if (state == EX_RUN && !pipelineHold) begin
        moveFromData <= copro_data_bus_in;
      end
    end
  end

  sequence s_entry;
    run && coreExecuteValid;
  endsequence

  sequence s_free_run;
    run && !coreInterlock;
  endsequence

  a_decode_flag: assert property (@(posedge clk) disable iff (!rst_n)
    run |=> decode_entry_flag == $past(coreDecodeValid))
    else $error("decode entry flag mismatch");

  a_exec_flag: assert property (@(posedge clk) disable iff (!rst_n)
    run |=> execute_entry_flag == $past(coreExecuteValid))
    else $error("execute entry flag mismatch");

  a_instr_bits: assert property (@(posedge clk) disable iff (!rst_n)
    run && coreDecodeValid && isCopro |=> copro_instr_bits == $past(coreDecodeInstr[INSTR_W-1:0]))
    else $error("coprocessor instruction bits wrong");

  a_noncopro_tag: assert property (@(posedge clk) disable iff (!rst_n)
    run && coreDecodeValid && !isCopro |=> copro_instr_bits[25:24] == NON_COPRO_TAG)
    else $error("non-coprocessor tag wrong");

  a_priv_track: assert property (@(posedge clk) disable iff (!rst_n)
    decode_entry_flag |-> privilege_level_output == $past(corePrivileged) || $past(!run))
    else $error("privilege output wrong");

  a_commit_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_entry ##1 (s_free_run and (!entryWait && !pipelineHold)) |=> commitStrobe)
    else $error("commit not one cycle after entry");

  a_bounce_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    bounceStrobe |-> commitStrobe && !commit_flag)
    else $error("bounced instruction committed");

  a_wait_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state == EX_WAIT && run && execute_wait_continue && !execute_reject_input |=> !commitStrobe)
    else $error("commit during busy-wait");

  a_hold_post: assert property (@(posedge clk) disable iff (!rst_n)
    state == EX_RUN && pipelineHold && run |=> !commitStrobe && state == EX_RUN)
    else $error("commit during interlock");

  a_bus_input: assert property (@(posedge clk) disable iff (!rst_n)
    !copro_data_bus_oe)
    else $error("data bus driven");

  a_stall_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> $stable(state) && $stable(decode_entry_flag))
    else $error("pipeline moved during stall");

endmodule

/* tb_coprocessor_handshake_port.sv */
// Self-checking bench for the coprocessor handshake port
module tb_coprocessor_handshake_port;
  import copro_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, coreDecodeValid = 1'b0, corePrivileged = 1'b0, coreExecuteValid = 1'b0;
  logic coreCondPass = 1'b0, coreInterlock = 1'b0, memStall = 1'b0, wantWait = 1'b0, wantBounce = 1'b0;
  logic rejD = 1'b0;
  logic [7:0] waitLen = 8'h00;
  logic [DATA_W-1:0] coreDecodeInstr = '0, coreMoveToData = '0, regValue = '0, copro_data_bus_in;
  logic [DATA_W-1:0] copro_data_bus_out, virtual_addr_bus, moveFromData, ins;
  logic decode_reject_input, execute_reject_input, decode_wait_request, execute_wait_continue, copro_data_bus_oe;
  logic decode_entry_flag, execute_entry_flag, commit_flag, commitStrobe, bounceStrobe, pipelineHold;
  logic privilege_level_output, internalRun;
  logic [7:0] doneCount;
  logic [INSTR_W-1:0] copro_instr_bits;
  logic [26:0] decQ[$], d;
  logic [1:0] comQ[$], c;
  int num_errors = 0, checks = 0, expDone = 0;
  always #5 clk = ~clk;
  coprocessor_handshake_port i_coprocessor_handshake_port (.clk, .rst_n, .coreDecodeValid, .coreDecodeInstr,
    .corePrivileged, .coreExecuteValid, .coreCondPass, .coreInterlock, .coreMoveToData, .memStall,
    .decode_reject_input, .execute_reject_input, .decode_wait_request, .execute_wait_continue, .copro_data_bus_in,
    .copro_data_bus_out, .copro_data_bus_oe, .copro_instr_bits, .decode_entry_flag, .execute_entry_flag,
    .commit_flag, .commitStrobe, .bounceStrobe, .pipelineHold, .privilege_level_output, .virtual_addr_bus,
    .moveFromData, .internalRun);
  copro_model i_copro_model (.clk, .rst_n, .internalRun, .execute_entry_flag, .wantWait, .wantBounce, .rejD,
    .waitLen, .regValue, .decode_reject_input, .decode_wait_request, .execute_wait_continue,
    .execute_reject_input, .copro_data_bus_in, .pipelineHold, .commitStrobe, .commit_flag, .doneCount);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Notes are taken off whenever a result pulse shows
  always @(negedge clk) begin
    if (rst_n && decode_entry_flag === 1'b1) begin
      d = decQ.pop_front();
      chk("instr bits", d[25:0], copro_instr_bits);
      chk("privilege", d[26], privilege_level_output);
    end
    if (rst_n && commitStrobe === 1'b1) begin
      c = comQ.pop_front();
      chk("commit", c[1], commit_flag);
      chk("bounce", c[0], bounceStrobe);
    end
  end
  task automatic dec(input logic [31:0] i, input logic p);
    @(posedge clk);
    coreDecodeValid <= 1'b1;
    coreDecodeInstr <= i;
    corePrivileged <= p;
    decQ.push_back({p, i[CLASS_HI:CLASS_LO] == COPRO_CLASS ? i[INSTR_W-1:0] : {NON_COPRO_TAG, 24'h000000}});
    @(posedge clk);
    coreDecodeValid <= 1'b0;
  endtask
  task automatic exec(input logic w, b, r, h, input logic [7:0] n, input logic cnd);
    int k;
    @(posedge clk);
    wantWait <= w;
    wantBounce <= b;
    rejD <= r;
    waitLen <= n;
    coreExecuteValid <= 1'b1;
    coreCondPass <= cnd;
    coreInterlock <= h;
    regValue <= $urandom;
    comQ.push_back({cnd & !(b & w) & !r, (b & w) | r});
    if (cnd && !(b && w) && !r) expDone++;
    @(posedge clk);
    coreExecuteValid <= 1'b0;
    #1 chk("exec entry", 1, execute_entry_flag);
    for (k = 0; k < 60 && commitStrobe !== 1'b1; k++) begin
      @(posedge clk);
      if (k == 3) coreInterlock <= 1'b0;
      #1;
    end
    if (k == 60) begin
      chk("commit wait", 0, 1);
      end_of_test();
    end
    chk("commit delay", 1, (r || !(w || h)) ? k == 1 : k > n);
    chk("move from", regValue, moveFromData);
    @(posedge clk);
  endtask
  initial begin
    void'($urandom(33));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      ins = $urandom;
      if (i % 2 == 0) ins[CLASS_HI:CLASS_LO] = COPRO_CLASS;
      else ins[CLASS_HI] = 1'b0;
      dec(ins, $urandom_range(0, 1));
    end
    @(posedge clk);
    #1 chk("idle bits", INSTR_IDLE, copro_instr_bits);
    chk("idle decode", 0, decode_entry_flag);
    exec(0, 0, 0, 0, 0, $urandom_range(0, 1));
    exec(1, 0, 0, 0, 3, $urandom_range(0, 1));
    exec(1, 1, 0, 0, 2, $urandom_range(0, 1));
    exec(0, 0, 1, 0, 0, $urandom_range(0, 1));
    exec(1, 0, 1, 0, 2, $urandom_range(0, 1));
    exec(0, 0, 0, 1, 3, $urandom_range(0, 1));
    exec(1, 0, 0, 0, 1, $urandom_range(0, 1));
    @(posedge clk);
    coreInterlock <= 1'b1;
    coreMoveToData <= $urandom;
    @(posedge clk);
    coreInterlock <= 1'b0;
    memStall <= 1'b1;
    #1 chk("hold", 1, pipelineHold);
    chk("move to", coreMoveToData, virtual_addr_bus);
    chk("bus oe", 0, copro_data_bus_oe);
    chk("bus out", DATA_RESET, copro_data_bus_out);
    repeat (3) @(posedge clk);
    memStall <= 1'b0;
    #1 chk("stalled", 0, internalRun);
    repeat (3) @(posedge clk);
    #1 chk("running", 1, internalRun);
    chk("notes left", 0, decQ.size() + comQ.size());
    chk("done count", expDone, doneCount);
    end_of_test();
  end
endmodule
